// *** design/pcie_root_port_link_caps.sv ***
// Link, slot, root and virtual channel register bank of the second graphics root port
//
// Contract
// - Link capability bits 31:24 are read-only and read 02h, matching the element port number.
// - Bits 17:15 are the write-once L1 exit latency, default 010b (2 us to under 4 us).
// - Bits 14:12 are the write-once L0s exit latency, default 010b (128 ns to under 256 ns).
// - Bits 11:10 are read-only and read 11b, L0s and L1 active-state entry supported.
// - Bits 9:4 are read-only and report eight lanes, 08h, in normal operation.
// - While single-lane forcing is enabled, bits 9:4 report one lane, 01h.
// - Bits 3:0 are read-only and read 1h, a 2.5 Gb/s maximum speed.
`timescale 1ns/1ps
module pcie_root_port_link_caps (
  input  wire logic                         clk_i,
  input  wire logic                         reset_i,
  input  wire root_port_link_pkg::cfg_req_s cfg_req_i,
  input  wire logic                         force_single_lane_i,
  output logic      [31:0]                  cfg_rdata_o,
  output logic                              cfg_ack_o,
  output logic      [2:0]                   l1_exit_latency_o,
  output logic      [2:0]                   l0s_exit_latency_o,
  output logic      [5:0]                   max_link_width_o
);
  import root_port_link_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  // Request decode
  logic [11:0] dword_addr;
  logic        wr_any;

  // Stored fields
  logic [2:0]  l1_exit;
  logic [2:0]  l0s_exit;
  logic [31:0] slot_capabilities;
  logic [15:0] link_control;
  logic [15:0] slot_control;
  logic [15:0] root_control;
  logic [31:0] legacy_control;
  logic [15:0] port_vc_control;
  logic [31:0] vc_zero_resource_control;
  logic [31:0] vc_one_resource_control;

  // Forcing pin path
  logic        force_meta;
  logic        force_sync_a;
  logic        force_sync_b;
  logic        force_single_lane;
  logic [5:0]  link_width;

  // Read path
  logic [31:0] link_capabilities;
  logic [31:0] next_rdata;

  // Write strobes
  logic        l1_wr;
  logic        l0s_wr;
  logic        slot_cap_wr;

  // Byte-lane merge of write data into a register
  function automatic logic [31:0] merge(input logic [31:0] old_value,
                                        input logic [31:0] wdata,
                                        input logic [3:0]  byte_en);
    logic [31:0] result;
    result = old_value;
    for (int i = 0; i < 4; i++) begin
      if (byte_en[i]) begin
        result[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    return result;
  endfunction : merge

  // Request decode on the aligned dword
  // Byte offset bits are ignored
  assign dword_addr = {cfg_req_i.addr[11:2], 2'b00};
  assign wr_any     = cfg_req_i.wr;

  // ----------------------------------------------------------------
  // Single-lane forcing input, three-stage synchroniser
  // ----------------------------------------------------------------
  // Pin is asynchronous; a change counts once stages two and three agree
  // Stages reset to the idle level of the pin
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      force_meta   <= 1'b0;
      force_sync_a <= 1'b0;
      force_sync_b <= 1'b0;
    end else begin
      force_meta   <= force_single_lane_i;
      force_sync_a <= force_meta;
      force_sync_b <= force_sync_a;
    end
  end

  // Filtered forcing level
  // Single-stage glitches never reach the width
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      force_single_lane <= 1'b0;
    end else if (force_sync_a == force_sync_b) begin
      force_single_lane <= force_sync_b;
    end
  end

  // Width reported in the capability register
  // Width follows the filtered level only
  assign link_width = force_single_lane ? WIDTH_ONE_LANE
                                        : WIDTH_EIGHT_LANES;

  // ----------------------------------------------------------------
  // Write-once fields
  // ----------------------------------------------------------------
  // A latency write counts only with every lane of the field enabled
  // A write missing a lane leaves the field open
  assign l1_wr  = wr_any && (dword_addr == LINK_CAPABILITIES_OFS)
                  && ((cfg_req_i.byte_en & L1_EXIT_LANES) == L1_EXIT_LANES);
  assign l0s_wr = wr_any && (dword_addr == LINK_CAPABILITIES_OFS)
                  && ((cfg_req_i.byte_en & L0S_EXIT_LANES) == L0S_EXIT_LANES);
  assign slot_cap_wr = wr_any && (dword_addr == SLOT_CAPABILITIES_OFS)
                       && (cfg_req_i.byte_en == FULL_DWORD_LANES);

  // L1 exit latency, first write wins
  // Each field locks on its own
  write_once_field #(
    .WIDTH       (3),
    .RESET_VALUE (L1_EXIT_RST)
  ) u_l1_exit (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .wr_i     (l1_wr),
    .data_i   (cfg_req_i.wdata[L1_EXIT_LSB +: 3]),
    .value_o  (l1_exit),
    .locked_o ()
  );

  // L0s exit latency, first write wins
  write_once_field #(
    .WIDTH       (3),
    .RESET_VALUE (L0S_EXIT_RST)
  ) u_l0s_exit (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .wr_i     (l0s_wr),
    .data_i   (cfg_req_i.wdata[L0S_EXIT_LSB +: 3]),
    .value_o  (l0s_exit),
    .locked_o ()
  );

  // Slot capabilities, written once as a whole dword
  // Partial writes dropped, whole dword locks at once
  write_once_field #(
    .WIDTH       (32),
    .RESET_VALUE (SLOT_CAPABILITIES_RST)
  ) u_slot_caps (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .wr_i     (slot_cap_wr),
    .data_i   (cfg_req_i.wdata),
    .value_o  (slot_capabilities),
    .locked_o ()
  );

  // Assembled link capability word
  // Reserved bits 23:18 read zero
  always_comb begin
    link_capabilities = '0;
    link_capabilities[PORT_NUMBER_LSB +: 8] = PORT_NUMBER_VAL;
    link_capabilities[L1_EXIT_LSB     +: 3] = l1_exit;
    link_capabilities[L0S_EXIT_LSB    +: 3] = l0s_exit;
    link_capabilities[ASPM_LSB        +: 2] = ASPM_SUPPORT_VAL;
    link_capabilities[LINK_WIDTH_LSB  +: 6] = link_width;
    link_capabilities[LINK_SPEED_LSB  +: 4] = SPEED_2G5_VAL;
  end

  // ----------------------------------------------------------------
  // Read-write control registers
  // ----------------------------------------------------------------
  // 16-bit controls sit in the low half of their dword
  // Upper halves hold status or zero, never written
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      link_control    <= LINK_CONTROL_RST;
      slot_control    <= SLOT_CONTROL_RST;
      root_control    <= ROOT_CONTROL_RST;
      port_vc_control <= PORT_VC_CONTROL_RST;
    end else if (wr_any) begin
      if (dword_addr == LINK_CONTROL_OFS) begin
        link_control <= 16'(merge({16'h0000, link_control},
                                  cfg_req_i.wdata, cfg_req_i.byte_en));
      end else if (dword_addr == SLOT_CONTROL_OFS) begin
        slot_control <= 16'(merge({16'h0000, slot_control},
                                  cfg_req_i.wdata, cfg_req_i.byte_en));
      end else if (dword_addr == ROOT_CONTROL_OFS) begin
        root_control <= 16'(merge({16'h0000, root_control},
                                  cfg_req_i.wdata, cfg_req_i.byte_en));
      end else if (dword_addr == PORT_VC_CONTROL_OFS) begin
        port_vc_control <= 16'(merge({16'h0000, port_vc_control},
                                     cfg_req_i.wdata, cfg_req_i.byte_en));
      end
    end
  end

  // 32-bit controls
  // Every lane of these words is writable
  // Writes elsewhere are acked and dropped
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      legacy_control           <= LEGACY_CONTROL_RST;
      vc_zero_resource_control <= VC_ZERO_RESOURCE_CONTROL_RST;
      vc_one_resource_control  <= VC_ONE_RESOURCE_CONTROL_RST;
    end else if (wr_any) begin
      if (dword_addr == LEGACY_CONTROL_OFS) begin
        legacy_control <= merge(legacy_control, cfg_req_i.wdata, cfg_req_i.byte_en);
      end else if (dword_addr == VC_ZERO_RESOURCE_CONTROL_OFS) begin
        vc_zero_resource_control <= merge(vc_zero_resource_control,
                                          cfg_req_i.wdata, cfg_req_i.byte_en);
      end else if (dword_addr == VC_ONE_RESOURCE_CONTROL_OFS) begin
        vc_one_resource_control <= merge(vc_one_resource_control,
                                         cfg_req_i.wdata, cfg_req_i.byte_en);
      end
    end
  end

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  // Unmapped dwords read zero; status halves sit above their controls
  // Reads have no side effects
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (dword_addr == LINK_CAPABILITIES_OFS) begin
      next_rdata = link_capabilities;
    end else if (dword_addr == LINK_CONTROL_OFS) begin
      next_rdata = {LINK_STATUS_RST, link_control};
    end else if (dword_addr == SLOT_CAPABILITIES_OFS) begin
      next_rdata = slot_capabilities;
    end else if (dword_addr == SLOT_CONTROL_OFS) begin
      next_rdata = {SLOT_STATUS_RST, slot_control};
    end else if (dword_addr == ROOT_CONTROL_OFS) begin
      next_rdata = {16'h0000, root_control};
    end else if (dword_addr == ROOT_STATUS_OFS) begin
      next_rdata = ROOT_STATUS_RST;
    end else if (dword_addr == LEGACY_CONTROL_OFS) begin
      next_rdata = legacy_control;
    end else if (dword_addr == VC_EXTENDED_CAP_HEADER_OFS) begin
      next_rdata = VC_EXTENDED_CAP_HEADER_RST;
    end else if (dword_addr == PORT_VC_CAPABILITY_ONE_OFS) begin
      next_rdata = PORT_VC_CAPABILITY_ONE_RST;
    end else if (dword_addr == PORT_VC_CAPABILITY_TWO_OFS) begin
      next_rdata = PORT_VC_CAPABILITY_TWO_RST;
    end else if (dword_addr == PORT_VC_CONTROL_OFS) begin
      next_rdata = {16'h0000, port_vc_control};
    end else if (dword_addr == VC_ZERO_RESOURCE_CAPABILITY_OFS) begin
      next_rdata = VC_ZERO_RESOURCE_CAPABILITY_RST;
    end else if (dword_addr == VC_ZERO_RESOURCE_CONTROL_OFS) begin
      next_rdata = vc_zero_resource_control;
    end else if (dword_addr == {VC_ZERO_RESOURCE_STATUS_OFS[11:2], 2'b00}) begin
      next_rdata = {VC_ZERO_RESOURCE_STATUS_RST, 16'h0000};
    end else if (dword_addr == VC_ONE_RESOURCE_CAPABILITY_OFS) begin
      next_rdata = VC_ONE_RESOURCE_CAPABILITY_RST;
    end else if (dword_addr == VC_ONE_RESOURCE_CONTROL_OFS) begin
      next_rdata = vc_one_resource_control;
    end else if (dword_addr == {VC_ONE_RESOURCE_STATUS_OFS[11:2], 2'b00}) begin
      next_rdata = {VC_ONE_RESOURCE_STATUS_RST, 16'h0000};
    end else if (dword_addr == LINK_DECLARATION_HEADER_OFS) begin
      next_rdata = LINK_DECLARATION_HEADER_RST;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  // Answer one cycle after each read or write
  // Zero outside reads, so no stale word looks valid
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cfg_rdata_o <= 32'h0000_0000;
      cfg_ack_o   <= 1'b0;
    end else begin
      cfg_ack_o   <= cfg_req_i.rd | cfg_req_i.wr;
      cfg_rdata_o <= cfg_req_i.rd ? next_rdata : 32'h0000_0000;
    end
  end

  // Live link capability fields for the port logic
  // Copies lag the register by one cycle
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      l1_exit_latency_o  <= L1_EXIT_RST;
      l0s_exit_latency_o <= L0S_EXIT_RST;
      max_link_width_o   <= WIDTH_EIGHT_LANES;
    end else begin
      l1_exit_latency_o  <= l1_exit;
      l0s_exit_latency_o <= l0s_exit;
      max_link_width_o   <= link_width;
    end
  end

endmodule : pcie_root_port_link_caps

// *** design/root_port_link_pkg.sv ***
// Constants and types for the second graphics root port link register bank
package root_port_link_pkg;

  // ----------------------------------------------------------------
  // Configuration access carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [3:0]  byte_en;
    logic [31:0] wdata;
  } cfg_req_s;

  // ----------------------------------------------------------------
  // Byte offsets of the bank, as printed
  // ----------------------------------------------------------------
  localparam logic [11:0] LINK_CAPABILITIES_OFS           = 12'h0ac;
  localparam logic [11:0] LINK_CONTROL_OFS                = 12'h0b0;
  localparam logic [11:0] LINK_STATUS_OFS                 = 12'h0b2;
  localparam logic [11:0] SLOT_CAPABILITIES_OFS           = 12'h0b4;
  localparam logic [11:0] SLOT_CONTROL_OFS                = 12'h0b8;
  localparam logic [11:0] SLOT_STATUS_OFS                 = 12'h0ba;
  localparam logic [11:0] ROOT_CONTROL_OFS                = 12'h0bc;
  localparam logic [11:0] ROOT_STATUS_OFS                 = 12'h0c0;
  localparam logic [11:0] LEGACY_CONTROL_OFS              = 12'h0ec;
  localparam logic [11:0] VC_EXTENDED_CAP_HEADER_OFS      = 12'h100;
  localparam logic [11:0] PORT_VC_CAPABILITY_ONE_OFS      = 12'h104;
  localparam logic [11:0] PORT_VC_CAPABILITY_TWO_OFS      = 12'h108;
  localparam logic [11:0] PORT_VC_CONTROL_OFS             = 12'h10c;
  localparam logic [11:0] VC_ZERO_RESOURCE_CAPABILITY_OFS = 12'h110;
  localparam logic [11:0] VC_ZERO_RESOURCE_CONTROL_OFS    = 12'h114;
  localparam logic [11:0] VC_ZERO_RESOURCE_STATUS_OFS     = 12'h11a;
  localparam logic [11:0] VC_ONE_RESOURCE_CAPABILITY_OFS  = 12'h11c;
  localparam logic [11:0] VC_ONE_RESOURCE_CONTROL_OFS     = 12'h120;
  localparam logic [11:0] VC_ONE_RESOURCE_STATUS_OFS      = 12'h126;
  localparam logic [11:0] LINK_DECLARATION_HEADER_OFS     = 12'h140;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [15:0] LINK_CONTROL_RST                = 16'h0000;
  localparam logic [15:0] LINK_STATUS_RST                 = 16'h1001;
  localparam logic [31:0] SLOT_CAPABILITIES_RST           = 32'h0000_0000;
  localparam logic [15:0] SLOT_CONTROL_RST                = 16'h01c0;
  localparam logic [15:0] SLOT_STATUS_RST                 = 16'h0000;
  localparam logic [15:0] ROOT_CONTROL_RST                = 16'h0000;
  localparam logic [31:0] ROOT_STATUS_RST                 = 32'h0000_0000;
  localparam logic [31:0] LEGACY_CONTROL_RST              = 32'h0000_0000;
  localparam logic [31:0] VC_EXTENDED_CAP_HEADER_RST      = 32'h1401_0002;
  localparam logic [31:0] PORT_VC_CAPABILITY_ONE_RST      = 32'h0000_0001;
  localparam logic [31:0] PORT_VC_CAPABILITY_TWO_RST      = 32'h0000_0001;
  localparam logic [15:0] PORT_VC_CONTROL_RST             = 16'h0000;
  localparam logic [31:0] VC_ZERO_RESOURCE_CAPABILITY_RST = 32'h0000_0000;
  localparam logic [31:0] VC_ZERO_RESOURCE_CONTROL_RST    = 32'h8000_00ff;
  localparam logic [15:0] VC_ZERO_RESOURCE_STATUS_RST     = 16'h0002;
  localparam logic [31:0] VC_ONE_RESOURCE_CAPABILITY_RST  = 32'h0000_8000;
  localparam logic [31:0] VC_ONE_RESOURCE_CONTROL_RST     = 32'h0100_0000;
  localparam logic [15:0] VC_ONE_RESOURCE_STATUS_RST      = 16'h0002;
  localparam logic [31:0] LINK_DECLARATION_HEADER_RST     = 32'h0001_0005;

  // ----------------------------------------------------------------
  // Link capability fields
  // ----------------------------------------------------------------
  localparam int          PORT_NUMBER_LSB       = 24;
  localparam int          L1_EXIT_LSB           = 15;
  localparam int          L0S_EXIT_LSB          = 12;
  localparam int          ASPM_LSB              = 10;
  localparam int          LINK_WIDTH_LSB        = 4;
  localparam int          LINK_SPEED_LSB        = 0;
  localparam logic [7:0]  PORT_NUMBER_VAL       = 8'h02;
  localparam logic [2:0]  L1_EXIT_RST           = 3'h2;
  localparam logic [2:0]  L0S_EXIT_RST          = 3'h2;
  localparam logic [1:0]  ASPM_SUPPORT_VAL      = 2'h3;
  localparam logic [5:0]  WIDTH_EIGHT_LANES     = 6'h08;
  localparam logic [5:0]  WIDTH_ONE_LANE        = 6'h01;
  localparam logic [3:0]  SPEED_2G5_VAL         = 4'h1;

  // Byte lanes that must be enabled for a write to a latency field or to slot capabilities
  localparam logic [3:0]  L1_EXIT_LANES         = 4'h6;
  localparam logic [3:0]  L0S_EXIT_LANES        = 4'h2;
  localparam logic [3:0]  FULL_DWORD_LANES      = 4'hf;

endpackage : root_port_link_pkg

// *** design/write_once_field.sv ***
// Field that keeps its default until the first write after reset
`timescale 1ns/1ps
module write_once_field #(
  parameter int                 WIDTH       = 3,
  parameter logic [WIDTH-1:0]   RESET_VALUE = '0
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic             wr_i,
  input  wire logic [WIDTH-1:0] data_i,
  output logic      [WIDTH-1:0] value_o,
  output logic                  locked_o
);

  // ----------------------------------------------------------------
  // Storage and lock
  // ----------------------------------------------------------------
  // First write stores and locks; later writes wait for reset
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      value_o  <= RESET_VALUE;
      locked_o <= 1'b0;
    end else if (wr_i && !locked_o) begin
      value_o  <= data_i;
      locked_o <= 1'b1;
    end
  end

endmodule : write_once_field

// *** verification/pcie_root_port_link_caps_chk.sv ***
// Port assertions for the link capability register bank
`timescale 1ns/1ps
module pcie_root_port_link_caps_chk
  import root_port_link_pkg::*;
(
  input  wire logic                         clk_i,
  input  wire logic                         reset_i,
  input  wire root_port_link_pkg::cfg_req_s cfg_req_i,
  input  wire logic                         force_single_lane_i,
  input  wire logic      [31:0]             cfg_rdata_o,
  input  wire logic                         cfg_ack_o,
  input  wire logic      [2:0]              l1_exit_latency_o,
  input  wire logic      [2:0]              l0s_exit_latency_o,
  input  wire logic      [5:0]              max_link_width_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  logic       cap_wr;
  logic       l1_done;
  logic       l0s_done;
  logic [2:0] hi_cnt;
  logic [2:0] lo_cnt;
  assign cap_wr = cfg_req_i.wr && cfg_req_i.addr[11:2] == LINK_CAPABILITIES_OFS[11:2];

  // Latency fields consumed by a write with the needed lanes
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      l1_done  <= 1'b0;
      l0s_done <= 1'b0;
    end else begin
      l1_done  <= l1_done | (cap_wr & cfg_req_i.byte_en[1] & cfg_req_i.byte_en[2]);
      l0s_done <= l0s_done | (cap_wr & cfg_req_i.byte_en[1]);
    end
  end

  // Cycles the forcing pin has stood at one level
  always_ff @(posedge clk_i) begin
    if (reset_i || !force_single_lane_i) hi_cnt <= 3'h0;
    else if (hi_cnt != 3'h7) hi_cnt <= hi_cnt + 3'h1;
    if (reset_i || force_single_lane_i) lo_cnt <= 3'h0;
    else if (lo_cnt != 3'h7) lo_cnt <= lo_cnt + 3'h1;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_cap_read;
    cfg_req_i.rd && cfg_req_i.addr[11:2] == LINK_CAPABILITIES_OFS[11:2];
  endsequence
  sequence s_any_req;
    cfg_req_i.rd || cfg_req_i.wr;
  endsequence

  a_ack_follows_req: assert property (s_any_req |=> cfg_ack_o)
    else $error("request not acknowledged");
  a_no_idle_ack: assert property (!(cfg_req_i.rd || cfg_req_i.wr) |=> !cfg_ack_o)
    else $error("acknowledge without request");
  a_idle_rdata: assert property (!cfg_req_i.rd |=> cfg_rdata_o == 32'h0000_0000)
    else $error("read data outside a read");
  a_port_number: assert property (s_cap_read |=> cfg_rdata_o[31:24] == PORT_NUMBER_VAL)
    else $error("port number wrong");
  a_aspm_support: assert property (s_cap_read |=> cfg_rdata_o[11:10] == ASPM_SUPPORT_VAL)
    else $error("power state support wrong");
  a_link_speed: assert property (s_cap_read |=> cfg_rdata_o[3:0] == SPEED_2G5_VAL)
    else $error("link speed wrong");
  a_l1_mirror: assert property (s_cap_read |=> cfg_rdata_o[17:15] == l1_exit_latency_o)
    else $error("L1 latency read and port differ");
  a_l0s_mirror: assert property (s_cap_read |=> cfg_rdata_o[14:12] == l0s_exit_latency_o)
    else $error("L0s latency read and port differ");
  a_width_eight: assert property (lo_cnt >= 3'h6 |-> max_link_width_o == WIDTH_EIGHT_LANES)
    else $error("width not eight lanes");
  a_width_one: assert property (hi_cnt >= 3'h6 |-> max_link_width_o == WIDTH_ONE_LANE)
    else $error("width not one lane");
  a_l1_held: assert property (l1_done |=> ##1 $stable(l1_exit_latency_o))
    else $error("L1 latency changed after lock");
  a_l1_default: assert property (!l1_done |-> l1_exit_latency_o == L1_EXIT_RST)
    else $error("L1 latency left default early");
  a_l0s_default: assert property (!l0s_done |-> l0s_exit_latency_o == L0S_EXIT_RST)
    else $error("L0s latency left default early");
endmodule : pcie_root_port_link_caps_chk

bind pcie_root_port_link_caps pcie_root_port_link_caps_chk u_chk (
  .clk_i(clk_i), .reset_i(reset_i), .cfg_req_i(cfg_req_i),
  .force_single_lane_i(force_single_lane_i), .cfg_rdata_o(cfg_rdata_o),
  .cfg_ack_o(cfg_ack_o), .l1_exit_latency_o(l1_exit_latency_o),
  .l0s_exit_latency_o(l0s_exit_latency_o), .max_link_width_o(max_link_width_o));

// *** verification/cfg_host_model.sv ***
// Host side model issuing configuration accesses
`timescale 1ns/1ps
module cfg_host_model
  import root_port_link_pkg::*;
(
  input  wire logic                     clk_i,
  input  wire logic [31:0]              cfg_rdata_i,
  input  wire logic                     cfg_ack_i,
  output root_port_link_pkg::cfg_req_s  cfg_req_o
);
  initial cfg_req_o = '0;

  // One access: pulse at a falling edge, collect the answer one cycle later
  // Whole access in one request, so no split latency value is left behind
  task automatic access(input logic is_wr, input logic [11:0] addr, input logic [3:0] be,
                        input logic [31:0] wdata, output logic [31:0] rdata,
                        output logic ack);
    @(negedge clk_i);
    cfg_req_o = '{rd: !is_wr, wr: is_wr, addr: addr, byte_en: be, wdata: wdata};
    @(negedge clk_i);
    ack   = cfg_ack_i;
    rdata = cfg_rdata_i;
    // Released lines no longer show the last value
    cfg_req_o = '{rd: 1'b0, wr: 1'b0, addr: ~addr, byte_en: ~be, wdata: ~wdata};
  endtask : access
endmodule : cfg_host_model

// *** verification/tb_pcie_root_port_link_caps.sv ***
// Self-checking bench for the link capability register bank
`timescale 1ns/1ps
module tb_pcie_root_port_link_caps;
  import root_port_link_pkg::*;
`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end

  logic                 clk_i = 1'b0;
  logic                 reset_i = 1'b1;
  logic                 force_single_lane_i = 1'b0;
  cfg_req_s             cfg_req;
  logic [31:0]          cfg_rdata;
  logic                 cfg_ack;
  logic [2:0]           l1_lat;
  logic [2:0]           l0s_lat;
  logic [5:0]           width;
  int                   n_errors = 0;
  int                   total_checks = 0;
  localparam logic [11:0] CAP = LINK_CAPABILITIES_OFS;
  localparam logic [11:0] TAB_ADDR [17] = '{12'h0b0, 12'h0b4, 12'h0b8, 12'h0bc, 12'h0c0,
    12'h0ec, 12'h100, 12'h104, 12'h108, 12'h10c, 12'h110, 12'h114, 12'h118, 12'h11c,
    12'h120, 12'h124, 12'h0f0};
  localparam logic [31:0] TAB_EXP [17] = '{{LINK_STATUS_RST, LINK_CONTROL_RST},
    SLOT_CAPABILITIES_RST, {SLOT_STATUS_RST, SLOT_CONTROL_RST}, {16'h0000, ROOT_CONTROL_RST},
    ROOT_STATUS_RST, LEGACY_CONTROL_RST, VC_EXTENDED_CAP_HEADER_RST,
    PORT_VC_CAPABILITY_ONE_RST, PORT_VC_CAPABILITY_TWO_RST, {16'h0000, PORT_VC_CONTROL_RST},
    VC_ZERO_RESOURCE_CAPABILITY_RST, VC_ZERO_RESOURCE_CONTROL_RST,
    {VC_ZERO_RESOURCE_STATUS_RST, 16'h0000}, VC_ONE_RESOURCE_CAPABILITY_RST,
    VC_ONE_RESOURCE_CONTROL_RST, {VC_ONE_RESOURCE_STATUS_RST, 16'h0000}, 32'h0000_0000};

  always #20 clk_i = ~clk_i;

  pcie_root_port_link_caps i_pcie_root_port_link_caps (
    .clk_i(clk_i), .reset_i(reset_i), .cfg_req_i(cfg_req),
    .force_single_lane_i(force_single_lane_i), .cfg_rdata_o(cfg_rdata), .cfg_ack_o(cfg_ack),
    .l1_exit_latency_o(l1_lat), .l0s_exit_latency_o(l0s_lat), .max_link_width_o(width));
  cfg_host_model u_host (
    .clk_i(clk_i), .cfg_rdata_i(cfg_rdata), .cfg_ack_i(cfg_ack), .cfg_req_o(cfg_req));

  // ----------------------------------------------------------------
  // Access tasks and expected link capability word
  // ----------------------------------------------------------------
  function automatic logic [31:0] cap_exp(logic [2:0] l1, logic [2:0] l0s, logic [5:0] w);
    return {PORT_NUMBER_VAL, 6'h00, l1, l0s, ASPM_SUPPORT_VAL, w, SPEED_2G5_VAL};
  endfunction : cap_exp

  task automatic wr(input logic [11:0] addr, input logic [3:0] be, input logic [31:0] d);
    logic [31:0] rd_d;
    logic        ack;
    u_host.access(1'b1, addr, be, d, rd_d, ack);
    `CHECK(ack, 1'b1)
  endtask : wr

  task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp);
    logic [31:0] rd_d;
    logic        ack;
    u_host.access(1'b0, addr, 4'h0, 32'h0000_0000, rd_d, ack);
    `CHECK(ack, 1'b1)
    `CHECK(rd_d, exp)
  endtask : rd_chk

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_i);
    @(negedge clk_i) reset_i = 1'b0;
    rd_chk(CAP, cap_exp(L1_EXIT_RST, L0S_EXIT_RST, WIDTH_EIGHT_LANES));
    for (int i = 0; i < 17; i++) rd_chk(TAB_ADDR[i], TAB_EXP[i]);
    // Writes to fixed places change nothing
    wr(CAP, 4'h9, 32'hffff_ffff);
    wr(LINK_DECLARATION_HEADER_OFS, 4'hf, 32'hffff_ffff);
    wr(12'h0f0, 4'hf, 32'hffff_ffff);
    rd_chk(CAP, cap_exp(L1_EXIT_RST, L0S_EXIT_RST, WIDTH_EIGHT_LANES));
    rd_chk(LINK_DECLARATION_HEADER_OFS, LINK_DECLARATION_HEADER_RST);
    rd_chk(12'h0f0, 32'h0000_0000);
    // Half of the L1 field alone is not taken
    wr(CAP, 4'h4, 32'h0003_8000);
    repeat (2) @(negedge clk_i);
    `CHECK(l1_lat, L1_EXIT_RST)
    wr(CAP, 4'h6, 32'h0002_b000);
    rd_chk(CAP, cap_exp(3'h5, 3'h3, WIDTH_EIGHT_LANES));
    `CHECK(l1_lat, 3'h5)
    `CHECK(l0s_lat, 3'h3)
    wr(CAP, 4'hf, 32'hffff_ffff);
    rd_chk(CAP, cap_exp(3'h5, 3'h3, WIDTH_EIGHT_LANES));
    // Mid-run reset reopens both fields
    @(negedge clk_i) reset_i = 1'b1;
    repeat (2) @(negedge clk_i);
    reset_i = 1'b0;
    `CHECK(l1_lat, L1_EXIT_RST)
    wr(CAP, 4'h2, 32'h0000_6000);
    rd_chk(CAP, cap_exp(L1_EXIT_RST, 3'h6, WIDTH_EIGHT_LANES));
    wr(CAP, 4'h6, 32'h0000_8000);
    rd_chk(CAP, cap_exp(3'h1, 3'h6, WIDTH_EIGHT_LANES));
    // Single-lane forcing and its removal
    force_single_lane_i = 1'b1;
    repeat (8) @(negedge clk_i);
    `CHECK(width, WIDTH_ONE_LANE)
    rd_chk(CAP, cap_exp(3'h1, 3'h6, WIDTH_ONE_LANE));
    force_single_lane_i = 1'b0;
    repeat (8) @(negedge clk_i);
    `CHECK(width, WIDTH_EIGHT_LANES)
    rd_chk(CAP, cap_exp(3'h1, 3'h6, WIDTH_EIGHT_LANES));
    // Plain read-write registers, whole and per lane
    wr(SLOT_CONTROL_OFS, 4'hf, 32'hffff_a55a);
    rd_chk(SLOT_CONTROL_OFS, {SLOT_STATUS_RST, 16'ha55a});
    wr(VC_ZERO_RESOURCE_CONTROL_OFS, 4'h2, 32'h0000_3c00);
    rd_chk(VC_ZERO_RESOURCE_CONTROL_OFS, {VC_ZERO_RESOURCE_CONTROL_RST[31:16], 8'h3c,
      VC_ZERO_RESOURCE_CONTROL_RST[7:0]});
    // Slot capabilities: partial write refused, then first full write locks
    wr(SLOT_CAPABILITIES_OFS, 4'h7, 32'hffff_ffff);
    wr(SLOT_CAPABILITIES_OFS, 4'hf, 32'h1234_5678);
    wr(SLOT_CAPABILITIES_OFS, 4'hf, 32'hffff_ffff);
    rd_chk(SLOT_CAPABILITIES_OFS, 32'h1234_5678);
    complete_run();
  end

  // Watchdog well beyond the hundred or so cycles of the sequence
  initial begin
    #2_000_000;
    n_errors++;
    complete_run();
  end
endmodule : tb_pcie_root_port_link_caps
